/* hw/fsr_pkg.sv */
// fsr_pkg: constants and types of the floppy status and format block.
// assumes one 10 MHz clock; every byte-time cycle count is derived from its period.
package fsr_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS      = 100;
  localparam int BYTE_TIME_FM_NS    = 32000;
  localparam int BYTE_TIME_MFM_NS   = 16000;
  localparam int BYTE_CYC_FM        = (BYTE_TIME_FM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_CYC_MFM       = (BYTE_TIME_MFM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_CNT_W         = 9;
  localparam logic [1:0] LOAD_TIMEOUT_BYTES = 2'h3;
  localparam logic [2:0] ADDR_SEARCH_REVS   = 3'h6;
  localparam logic [1:0] SYNC_COUNT         = 2'h3;

  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [1:0] REG_STATUS    = 2'h0;
  localparam logic [1:0] REG_HOST_BYTE = 2'h1;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] HOST_BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------
  // format byte codes
  // ----------------------------------------
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] BYTE_SYNC_CMD = 8'hF5;
  localparam logic [7:0] BYTE_C2_CMD   = 8'hF6;
  localparam logic [7:0] BYTE_CRC2     = 8'hF7;
  localparam logic [7:0] BYTE_MARK_LO  = 8'hF8;
  localparam logic [7:0] BYTE_MARK_HI  = 8'hFB;
  localparam logic [7:0] BYTE_ID_MARK  = 8'hFE;
  localparam logic [7:0] BYTE_A1       = 8'hA1;
  localparam logic [7:0] BYTE_C2       = 8'hC2;

  // ----------------------------------------
  // sector sizes by length code
  // ----------------------------------------
  localparam logic [10:0] SECT_BYTES_0 = 11'h080;
  localparam logic [10:0] SECT_BYTES_1 = 11'h100;
  localparam logic [10:0] SECT_BYTES_2 = 11'h200;
  localparam logic [10:0] SECT_BYTES_3 = 11'h400;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {CMD_T1, CMD_T2, CMD_T3} fsr_cmd_kind_type;

  typedef struct packed {
    logic             start;
    fsr_cmd_kind_type kind;
    logic             write;
    logic             format;
    logic             rdaddr;
  } fsr_cmd_type;

  typedef struct packed {
    logic       strobe;
    logic [7:0] data;
    logic       missing_clk;
    logic       crc2;
    logic       crc_preset;
  } fsr_disk_word_type;

  typedef enum {F_IDLE, F_LOAD, F_INDEX, F_WRITE} fsr_fmt_state_type;

endpackage

/* hw/fsr_byte_timer.sv */
// fsr_byte_timer: one-cycle pulse per disk byte time.
// assumes the density input is steady while run is high.
`timescale 1ns/1ps
`default_nettype none
module fsr_byte_timer
  import fsr_pkg::*;
#(
  parameter int CYC_FM  = BYTE_CYC_FM,
  parameter int CYC_MFM = BYTE_CYC_MFM
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic mfm,
  output logic      tick
);

  logic [BYTE_CNT_W-1:0] cnt_q;
  logic [BYTE_CNT_W-1:0] cnt_d;
  logic [BYTE_CNT_W-1:0] last;

  always_comb begin
    last = mfm ? BYTE_CNT_W'(CYC_MFM - 1) : BYTE_CNT_W'(CYC_FM - 1);
    tick = run && (cnt_q == last);
    if (!run || tick) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // fsr_byte_timer
`default_nettype wire

/* hw/fsr_status.sv */
// fsr_status: status word, host byte register and track-format byte feed.
// assumes a command sequencer drives CMD and the event pulses, all synchronous.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsr_status
  import fsr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic [1:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire fsr_cmd_type CMD,
  input  wire logic        CMD_DONE,
  input  wire logic        FORCE_INT,
  input  wire logic        SPINUP_EV,
  input  wire logic        DELETED_EV,
  input  wire logic        RNF_EV,
  input  wire logic        CRC_EV,
  input  wire logic        TX_TAKE,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_SYNC,
  input  wire logic        RX_ID,
  input  wire logic [1:0]  SECTOR_CODE,
  input  wire logic        SPINDLE_RUNNING,
  input  wire logic        WRITE_PROTECTED,
  input  wire logic        TRACK_ZERO_SENSE,
  input  wire logic        INDEX_LEVEL,
  input  wire logic        DENSITY_SELECT_N,
  output logic             HOST_BYTE_REQUEST,
  output logic             COMPLETION_IRQ,
  output logic             COMMAND_ACTIVE,
  output fsr_disk_word_type DISK,
  output logic             MARK_FOUND,
  output logic      [10:0] SECTOR_BYTES
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic busy_q, busy_d, view_t1_q, view_t1_d, wp_track_q, wp_track_d;
  logic s6_q, s6_d, s5_q, s5_d, s4_q, s4_d, s3_q, s3_d, ld_q, ld_d;
  logic req_q, req_d, irq_q, irq_d, wr_cmd_q, wr_cmd_d, rdaddr_q, rdaddr_d;
  logic addr_seen_q, addr_seen_d, index_q, mark_q, mark_d;
  logic [7:0]  hbr_q, hbr_d, rdata_q, rdata_d, st;
  logic [1:0]  wait_cnt_q, wait_cnt_d, sync_cnt_q, sync_cnt_d;
  logic [2:0]  idx_cnt_q, idx_cnt_d;
  logic [10:0] sect_q, sect_d;
  fsr_fmt_state_type fmt_q, fmt_d;
  fsr_disk_word_type disk_q, disk_d;

  logic rd_status, rd_hbr, wr_hbr, index_rise, tick, need, done, ld_set;

  assign rd_status  = RD && (ADDR == REG_STATUS);
  assign rd_hbr     = RD && (ADDR == REG_HOST_BYTE);
  assign wr_hbr     = WR && (ADDR == REG_HOST_BYTE);
  assign index_rise = INDEX_LEVEL && !index_q;

  fsr_byte_timer i_fsr_byte_timer (
    .clk  (MCLK),
    .rst  (RESET),
    .run  ((fmt_q == F_LOAD) || (fmt_q == F_WRITE)),
    .mfm  (!DENSITY_SELECT_N),
    .tick (tick)
  );

  // format byte translation
  function automatic fsr_disk_word_type encode(input logic [7:0] b, input logic mfm);
    fsr_disk_word_type w;
    w = '{strobe: 1'b1, data: b, missing_clk: 1'b0, crc2: 1'b0, crc_preset: 1'b0};
    if (b == BYTE_CRC2) begin
      w.crc2 = 1'b1;
    end else if (mfm && (b == BYTE_SYNC_CMD)) begin
      w.data        = BYTE_A1;
      w.missing_clk = 1'b1;
      w.crc_preset  = 1'b1;
    end else if (mfm && (b == BYTE_C2_CMD)) begin
      w.data        = BYTE_C2;
      w.missing_clk = 1'b1;
    end else if (!mfm && (((b >= BYTE_MARK_LO) && (b <= BYTE_MARK_HI)) || (b == BYTE_ID_MARK))) begin
      w.missing_clk = 1'b1;
      w.crc_preset  = 1'b1;
    end
    return w;
  endfunction

  // ----------------------------------------
  // status word view
  // ----------------------------------------
  always_comb begin
    st[7] = SPINDLE_RUNNING;
    st[6] = wp_track_q ? WRITE_PROTECTED : s6_q;
    st[5] = s5_q;
    st[4] = s4_q;
    st[3] = s3_q;
    st[2] = view_t1_q ? TRACK_ZERO_SENSE : ld_q;
    st[1] = (view_t1_q || !busy_q) ? INDEX_LEVEL : req_q;
    st[0] = busy_q;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    busy_d = busy_q;  view_t1_d = view_t1_q;  wp_track_d = wp_track_q;
    s6_d = s6_q;  s5_d = s5_q;  s4_d = s4_q;  s3_d = s3_q;  ld_d = ld_q;
    req_d = req_q;  irq_d = irq_q;  hbr_d = hbr_q;
    wr_cmd_d = wr_cmd_q;  rdaddr_d = rdaddr_q;  addr_seen_d = addr_seen_q;
    wait_cnt_d = wait_cnt_q;  idx_cnt_d = idx_cnt_q;  fmt_d = fmt_q;
    sync_cnt_d = sync_cnt_q;  mark_d = 1'b0;
    done = CMD_DONE;
    ld_set = 1'b0;
    need = TX_TAKE && (fmt_q == F_IDLE);
    rdata_d = READ_UNMAPPED;

    if (rd_status) begin
      rdata_d = st;
      irq_d = 1'b0;
    end
    if (rd_hbr) begin
      rdata_d = hbr_q;
    end
    if (rd_hbr || wr_hbr) begin
      req_d = 1'b0;
    end
    if (wr_hbr) begin
      hbr_d = WDATA;
    end

    case (fmt_q)
      F_IDLE: begin
      end
      F_LOAD: begin
        if (wr_hbr) begin
          fmt_d = F_INDEX;
        end else if (tick) begin
          if (wait_cnt_q == LOAD_TIMEOUT_BYTES - 2'h1) begin
            ld_set = 1'b1;
            done   = 1'b1;
          end else begin
            wait_cnt_d = wait_cnt_q + 2'h1;
          end
        end
      end
      F_INDEX: begin
        if (index_rise) begin
          fmt_d = F_WRITE;
          need  = 1'b1;
        end
      end
      F_WRITE: begin
        if (index_rise) begin
          done = 1'b1;
        end else begin
          need = tick;
        end
      end
      default: fmt_d = F_IDLE;
    endcase

    disk_d = '0;
    if (need) begin
      disk_d = encode(req_q ? BYTE_ZERO : hbr_q, !DENSITY_SELECT_N);
      if (req_q) begin
        ld_set = 1'b1;
      end
      req_d = 1'b1;
    end
    if (RX_VALID) begin
      hbr_d = RX_BYTE;
      if (req_q) begin
        ld_set = 1'b1;
      end
      req_d = 1'b1;
    end

    if (busy_q && rdaddr_q) begin
      if (RX_ID) begin
        addr_seen_d = 1'b1;
      end
      if (index_rise) begin
        if ((idx_cnt_q == ADDR_SEARCH_REVS - 3'h1) && !addr_seen_q && !RX_ID) begin
          s4_d = 1'b1;
          done = 1'b1;
        end else begin
          idx_cnt_d = idx_cnt_q + 3'h1;
        end
      end
    end

    if (CMD.start && !FORCE_INT) begin
      busy_d = 1'b1;  view_t1_d = (CMD.kind == CMD_T1);  wp_track_d = 1'b0;
      s6_d = CMD.write && WRITE_PROTECTED;
      s5_d = 1'b0;  s4_d = 1'b0;  s3_d = 1'b0;  ld_d = 1'b0;
      req_d = CMD.write;
      wr_cmd_d = CMD.write;  rdaddr_d = CMD.rdaddr;
      addr_seen_d = 1'b0;  idx_cnt_d = '0;  wait_cnt_d = '0;
      fmt_d = CMD.format ? F_LOAD : F_IDLE;
      done = 1'b0;
    end

    if (FORCE_INT) begin
      busy_d = 1'b0;
      fmt_d  = F_IDLE;
      done   = 1'b0;
      if (!busy_q) begin
        view_t1_d = 1'b1;  wp_track_d = 1'b1;
        s6_d = 1'b0;  s5_d = 1'b0;  s4_d = 1'b0;  s3_d = 1'b0;  ld_d = 1'b0;
        req_d = 1'b0;
      end
    end

    // spin-up, record kind, verify fail, missing, crc
    if (SPINUP_EV || DELETED_EV) begin
      s5_d = 1'b1;
    end
    if (RNF_EV) begin
      s4_d = 1'b1;
    end
    if (CRC_EV) begin
      s3_d = 1'b1;
    end
    if (busy_q && wr_cmd_q && WRITE_PROTECTED) begin
      s6_d = 1'b1;
    end
    if (ld_set) begin
      ld_d = 1'b1;
    end

    if (done && busy_q) begin
      busy_d     = 1'b0;
      irq_d      = 1'b1;
      wp_track_d = view_t1_q;
      fmt_d      = F_IDLE;
    end

    if (RX_SYNC) begin
      if (sync_cnt_q != SYNC_COUNT) begin
        sync_cnt_d = sync_cnt_q + 2'h1;
      end
    end else if (RX_VALID) begin
      mark_d     = (DENSITY_SELECT_N || (sync_cnt_q == SYNC_COUNT)) && (RX_BYTE >= BYTE_MARK_LO);
      sync_cnt_d = '0;
    end

    case (SECTOR_CODE)
      2'h0:    sect_d = SECT_BYTES_0;
      2'h1:    sect_d = SECT_BYTES_1;
      2'h2:    sect_d = SECT_BYTES_2;
      default: sect_d = SECT_BYTES_3;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      busy_q <= 1'b0;  view_t1_q <= 1'b1;  wp_track_q <= 1'b1;
      s6_q <= 1'b0;  s5_q <= 1'b0;  s4_q <= 1'b0;  s3_q <= 1'b0;  ld_q <= 1'b0;
      req_q <= 1'b0;  irq_q <= 1'b0;  hbr_q <= HOST_BYTE_RESET;  rdata_q <= STATUS_RESET;
      wr_cmd_q <= 1'b0;  rdaddr_q <= 1'b0;  addr_seen_q <= 1'b0;  index_q <= 1'b0;
      wait_cnt_q <= '0;  idx_cnt_q <= '0;  sync_cnt_q <= '0;  mark_q <= 1'b0;
      fmt_q <= F_IDLE;  disk_q <= '0;  sect_q <= SECT_BYTES_0;
    end else begin
      busy_q <= busy_d;  view_t1_q <= view_t1_d;  wp_track_q <= wp_track_d;
      s6_q <= s6_d;  s5_q <= s5_d;  s4_q <= s4_d;  s3_q <= s3_d;  ld_q <= ld_d;
      req_q <= req_d;  irq_q <= irq_d;  hbr_q <= hbr_d;  rdata_q <= rdata_d;
      wr_cmd_q <= wr_cmd_d;  rdaddr_q <= rdaddr_d;  addr_seen_q <= addr_seen_d;  index_q <= INDEX_LEVEL;
      wait_cnt_q <= wait_cnt_d;  idx_cnt_q <= idx_cnt_d;  sync_cnt_q <= sync_cnt_d;  mark_q <= mark_d;
      fmt_q <= fmt_d;  disk_q <= disk_d;  sect_q <= sect_d;
    end
  end

  assign RDATA             = rdata_q;
  assign HOST_BYTE_REQUEST = req_q;
  assign COMPLETION_IRQ    = irq_q;
  assign COMMAND_ACTIVE    = busy_q;
  assign DISK              = disk_q;
  assign MARK_FOUND        = mark_q;
  assign SECTOR_BYTES      = sect_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // motor bit
  property p_motor_bit;
    @(posedge MCLK) disable iff (RESET) rd_status |=> (RDATA[7] == $past(SPINDLE_RUNNING));
  endproperty
  a_motor_bit: assert property (p_motor_bit) else $error("motor bit wrong");

  property p_busy_start;
    @(posedge MCLK) disable iff (RESET) (CMD.start && !FORCE_INT) |=> COMMAND_ACTIVE;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set");

  property p_force_busy;
    @(posedge MCLK) disable iff (RESET) (FORCE_INT && busy_q && !SPINUP_EV && !DELETED_EV && !RNF_EV && !CRC_EV
      && !ld_set) |=> (!busy_q && ({s5_q, s4_q, s3_q, ld_q, view_t1_q} == $past({s5_q, s4_q, s3_q, ld_q, view_t1_q})));
  endproperty
  a_force_busy: assert property (p_force_busy) else $error("force while busy changed bits");

  property p_force_idle;
    @(posedge MCLK) disable iff (RESET) (FORCE_INT && !busy_q) |=> (view_t1_q && !busy_q && wp_track_q);
  endproperty
  a_force_idle: assert property (p_force_idle) else $error("force while idle not type I");

  property p_irq_clear;
    @(posedge MCLK) disable iff (RESET) (rd_status && !(done && busy_q)) |=> !COMPLETION_IRQ;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read kept irq");

  property p_req_clear;
    @(posedge MCLK) disable iff (RESET) ((rd_hbr || wr_hbr) && !need && !RX_VALID && !CMD.start) |=> !HOST_BYTE_REQUEST;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("access kept request");

  property p_overrun;
    @(posedge MCLK) disable iff (RESET) (need && req_q && !FORCE_INT && !CMD.start) |=> ld_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_format_end;
    @(posedge MCLK) disable iff (RESET) (fmt_q == F_WRITE && index_rise && !FORCE_INT && !CMD.start)
      |=> (!COMMAND_ACTIVE && COMPLETION_IRQ && (fmt_q == F_IDLE));
  endproperty
  a_format_end: assert property (p_format_end) else $error("format not ended at index");

  property p_crc2;
    @(posedge MCLK) disable iff (RESET) (need && !req_q && (hbr_q == BYTE_CRC2)) |=> (DISK.strobe && DISK.crc2);
  endproperty
  a_crc2: assert property (p_crc2) else $error("crc byte not generated");

  property p_req_per_byte;
    @(posedge MCLK) disable iff (RESET) DISK.strobe |-> HOST_BYTE_REQUEST || $past(FORCE_INT || CMD.start);
  endproperty
  a_req_per_byte: assert property (p_req_per_byte) else $error("byte without request");

  property p_drq_bit;
    @(posedge MCLK) disable iff (RESET) (rd_status && busy_q && !view_t1_q) |=> (RDATA[1] == $past(req_q));
  endproperty
  a_drq_bit: assert property (p_drq_bit) else $error("bit 1 not request");

endmodule // fsr_status
`default_nettype wire

/* sim/fsr_host_model.sv */
// fsr_host_model: host side of the register port, feeds format bytes.
// assumes the bench calls its tasks; one host byte per data request.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model
  import fsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic [7:0] rdata,
  output logic      [1:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr  = 2'h0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
    #1;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // ----------------------------------------
  // format feed
  // ----------------------------------------
  // mfm id header
  function automatic logic [7:0] hdr_byte(input int i);
    logic [7:0] id [0:5];
    id = '{8'hFE, 8'h05, 8'h00, 8'h01, 8'h01, 8'hF7};
    if (i < 12) return 8'h00;
    if (i < 15) return 8'hF5;
    return id[i-15];
  endfunction

  task automatic feed(input int n_fill);
    int t;
    for (int i = 0; i < 21 + n_fill; i++) begin
      t = 0;
      while (req !== 1'b1 && t < 400) begin
        @(posedge clk);
        #1;
        t++;
      end
      wr_reg(REG_HOST_BYTE, (i < 21) ? hdr_byte(i) : 8'h4E);
    end
  endtask
endmodule // fsr_host_model
`default_nettype wire

/* sim/tb_top.sv */
// tb_top: self-checking bench of the status and format block.
// assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsr_pkg::*;
;
  localparam logic [7:0] P_SPIN = 8'h01, P_DEL = 8'h02, P_RNF = 8'h04, P_CRC = 8'h08;
  localparam logic [7:0] P_DONE = 8'h10, P_FORCE = 8'h20, P_RX = 8'h40, P_SYNC = 8'h80;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  fsr_cmd_type       cmd = '0;
  logic        [7:0] pl = 8'h00;
  logic        [7:0] rxb = 8'h00;
  logic        [1:0] scode = 2'h0;
  logic              motor = 1'b1;
  logic              wp = 1'b1;
  logic              tz = 1'b1;
  logic              idx = 1'b0;
  logic              dsn = 1'b1;
  logic              take = 1'b0;
  logic        [1:0] addr;
  logic        [7:0] wdata;
  logic              wr;
  logic              rd;
  logic        [7:0] rdata;
  logic              req;
  logic              irq;
  logic              busy;
  fsr_disk_word_type disk;
  logic              mark;
  logic       [10:0] sbytes;
  logic       [10:0] seen_q[$];
  logic        [7:0] s;
  logic        [7:0] sp;
  int                n_errors = 0;
  int                n_checks = 0;

  always #50 mclk = ~mclk;

  fsr_host_model i_fsr_host_model (.clk(mclk), .req(req), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));

  fsr_status i_fsr_status (.MCLK(mclk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMD(cmd), .CMD_DONE(pl[4]), .FORCE_INT(pl[5]), .SPINUP_EV(pl[0]),
    .DELETED_EV(pl[1]), .RNF_EV(pl[2]), .CRC_EV(pl[3]), .TX_TAKE(take), .RX_VALID(pl[6]),
    .RX_BYTE(rxb), .RX_SYNC(pl[7]), .RX_ID(1'b0), .SECTOR_CODE(scode), .SPINDLE_RUNNING(motor),
    .WRITE_PROTECTED(wp), .TRACK_ZERO_SENSE(tz), .INDEX_LEVEL(idx), .DENSITY_SELECT_N(dsn),
    .HOST_BYTE_REQUEST(req), .COMPLETION_IRQ(irq), .COMMAND_ACTIVE(busy), .DISK(disk),
    .MARK_FOUND(mark), .SECTOR_BYTES(sbytes));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic st();
    i_fsr_host_model.rd_reg(REG_STATUS, s);
  endtask

  task automatic cmd_go(input fsr_cmd_kind_type k, input logic w, input logic f, input logic ra);
    @(posedge mclk);
    cmd <= '{1'b1, k, w, f, ra};
    @(posedge mclk);
    cmd.start <= 1'b0;
    #1;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge mclk);
    pl <= m;
    @(posedge mclk);
    pl <= 8'h00;
    #1;
  endtask

  task automatic idx_pulse();
    @(posedge mclk);
    idx <= 1'b1;
    repeat (3) @(posedge mclk);
    idx <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  function automatic logic [10:0] dw(input logic [7:0] b);
    if (b == BYTE_SYNC_CMD) return {BYTE_A1, 3'b101};
    return {b, 3'b000};
  endfunction

  // disk byte capture
  always @(posedge mclk) begin
    #1;
    if (disk.strobe === 1'b1) begin
      seen_q.push_back(disk[10:0]);
      chk(req, 1'b1, "req at strobe");
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_type1();
    motor <= 1'b0;
    tz <= 1'b0;
    idx <= 1'b1;
    cmd_go(CMD_T1, 1'b0, 1'b0, 1'b0);
    chk(busy, 1'b1, "busy");
    pulse(P_SPIN | P_RNF | P_CRC);
    st();
    chk(s & 8'hBF, 8'h3B, "t1 status");
    pulse(P_DONE);
    chk({busy, irq}, 2'b01, "t1 end");
    wp <= 1'b0;
    st();
    chk({irq, s[6]}, 2'b00, "irq clear, wp live");
  endtask

  task automatic t_write();
    motor <= 1'b1;
    wp <= 1'b1;
    cmd_go(CMD_T2, 1'b1, 1'b0, 1'b0);
    st();
    chk(s, 8'hC3, "write start");
    pulse(P_DEL);
    i_fsr_host_model.wr_reg(REG_HOST_BYTE, 8'h3C);
    chk(req, 1'b0, "req cleared");
    st();
    chk(s, 8'hE1, "deleted mark");
    @(posedge mclk);
    take <= 1'b1;
    repeat (2) @(posedge mclk);
    take <= 1'b0;
    #1;
    st();
    chk(s[2:1], 2'b11, "sector write overrun");
    pulse(P_DONE);
    wp <= 1'b0;
    st();
    chk({s[6], s[1], s[0]}, 3'b110, "wp held");
  endtask

  task automatic t_force();
    cmd_go(CMD_T2, 1'b0, 1'b0, 1'b0);
    rxb <= 8'h5A;
    pulse(P_RX | P_RNF | P_CRC);
    chk(req, 1'b1, "rx req");
    i_fsr_host_model.rd_reg(REG_HOST_BYTE, s);
    chk({s, req}, {8'h5A, 1'b0}, "rx byte");
    st();
    sp = s;
    pulse(P_FORCE);
    idx <= 1'b0;
    st();
    chk({s[7:2], s[0]}, {sp[7:2], 1'b0}, "force busy");
    tz <= 1'b1;
    wp <= 1'b1;
    pulse(P_FORCE);
    st();
    chk(s & 8'hC7, 8'hC4, "force idle");
  endtask

  task automatic t_rdaddr();
    cmd_go(CMD_T3, 1'b0, 1'b0, 1'b1);
    repeat (5) idx_pulse();
    chk(busy, 1'b1, "search");
    idx_pulse();
    chk({busy, irq}, 2'b01, "search end");
    st();
    chk(s[4], 1'b1, "not found");
  endtask

  task automatic t_mark(input logic mfm, input int ns, input logic exp);
    dsn <= ~mfm;
    rxb <= BYTE_ID_MARK;
    repeat (ns) pulse(P_SYNC);
    pulse(P_RX);
    chk(mark, exp, "mark");
  endtask

  task automatic t_timeout();
    dsn <= 1'b0;
    cmd_go(CMD_T3, 1'b1, 1'b1, 1'b0);
    repeat (3 * BYTE_CYC_MFM - 10) @(posedge mclk);
    #1;
    chk(busy, 1'b1, "load wait");
    repeat (20) @(posedge mclk);
    #1;
    chk({busy, irq}, 2'b01, "load timeout");
    st();
    chk(s[2], 1'b1, "lost byte");
  endtask

  task automatic t_format();
    int t;
    logic [7:0] b;
    seen_q.delete();
    cmd_go(CMD_T3, 1'b1, 1'b1, 1'b0);
    chk(req, 1'b1, "fmt req");
    fork
      i_fsr_host_model.feed(4);
      begin
        repeat (20) @(posedge mclk);
        idx_pulse();
      end
    join
    t = 0;
    while (seen_q.size() < 26 && t < 8000) begin
      @(posedge mclk);
      t++;
    end
    chk(11'(seen_q.size()), 11'd26, "strobes");
    for (int i = 0; i < 26; i++) begin
      b = (i < 21) ? i_fsr_host_model.hdr_byte(i) : ((i < 25) ? 8'h4E : 8'h00);
      if (b == BYTE_CRC2) chk(seen_q[i][2:0], 3'b010, "crc pair");
      else chk(seen_q[i], dw(b), "disk byte");
    end
    st();
    chk(s & 8'h45, 8'h45, "fmt status");
    idx_pulse();
    chk({busy, irq}, 2'b01, "fmt end");
    repeat (200) @(posedge mclk);
    chk(11'(seen_q.size()), 11'd26, "no byte after end");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    st();
    chk(s, 8'hC4, "reset view");
    i_fsr_host_model.rd_reg(2'h2, s);
    chk(s, READ_UNMAPPED, "unmapped");
    t_type1();
    t_write();
    t_force();
    t_rdaddr();
    t_mark(1'b1, 3, 1'b1);
    t_mark(1'b1, 2, 1'b0);
    t_mark(1'b0, 0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      scode <= c[1:0];
      repeat (2) @(posedge mclk);
      #1;
      chk(sbytes, 11'h080 << c, "size");
    end
    t_timeout();
    t_format();
    test_done();
  end

  // about 5000 cycles expected; six times that is a hang
  initial begin
    #3000000;
    n_errors++;
    $display("BAD %0t watchdog", $time);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
